// ==== scb_register_bank.sv ====
/*
  Serial-port register bank of the synthesizer configuration: instruction
  decode, whole-register write and read of the second control, delta tuning,
  ramp rate and first two profile registers.
  Assumes the serial pins are asynchronous and far slower than clock_in;
  bit order and pin mode arrive as levels from the first control register.
*/
`timescale 1ns/100ps
module scb_register_bank
  import scb_pkg::*;
(
  input  wire logic          clock_in,
  input  wire logic          resetn_in,
  input  wire logic          ce_in,
  input  wire logic          sclk_in,
  input  wire logic          cs_n_in,
  input  wire logic          sdio_in,
  input  wire logic          io_reset_in,
  input  wire logic          lsb_first_in,
  input  wire logic          sdio_input_only_in,
  output logic               sdio_out,
  output logic               sdio_oe_out,
  output logic               sdo_out,
  output logic               sdo_oe_out,
  output scb_second_control_s second_control_out,
  output logic [23:0]        rising_delta_tuning_out,
  output logic [23:0]        falling_delta_tuning_out,
  output logic [15:0]        rising_ramp_rate_out,
  output logic [15:0]        falling_ramp_rate_out,
  output scb_profile_s       profile_zero_out,
  output scb_profile_s       profile_one_out
);

  // ==========================================================================
  // Pin synchronisers
  logic sclk_s;
  logic cs_n_s;
  logic sdio_s;
  logic io_reset_s;

  scb_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sclk
  (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .pin_in    (sclk_in),
    .level_out (sclk_s)
  );

  scb_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_cs
  (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .pin_in    (cs_n_in),
    .level_out (cs_n_s)
  );

  scb_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sdio
  (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .pin_in    (sdio_in),
    .level_out (sdio_s)
  );

  scb_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_io_reset
  (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .pin_in    (io_reset_in),
    .level_out (io_reset_s)
  );

  // ==========================================================================
  // Serial clock edges; a high chip select suspends the cycle
  logic sclk_d;
  logic sclk_rise;
  logic sclk_fall;

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      sclk_d <= 1'b0;
    end
    else if (ce_in)
    begin
      sclk_d <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s & ~io_reset_s;
  assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s & ~io_reset_s;

  // ==========================================================================
  // Address decode helpers
  function automatic logic [3:0] reg_bytes(input logic [4:0] addr);
    if (addr == ADDR_FIRST_CONTROL)
      reg_bytes = LEN_FIRST_CONTROL;
    else if (addr == ADDR_SECOND_CONTROL)
      reg_bytes = LEN_SECOND_CONTROL;
    else if (addr == ADDR_RISING_DELTA || addr == ADDR_FALLING_DELTA)
      reg_bytes = LEN_DELTA;
    else if (addr == ADDR_RISING_RAMP || addr == ADDR_FALLING_RAMP)
      reg_bytes = LEN_RAMP;
    else if (addr >= ADDR_PROFILE_ZERO && addr <= ADDR_PROFILE_LAST)
      reg_bytes = LEN_PROFILE;
    else
      reg_bytes = LEN_UNMAPPED;
  endfunction

  // ==========================================================================
  // Transfer state
  scb_state_e             state;
  logic [7:0]             instr_shift;
  logic [7:0]             next_instr;
  logic [4:0]             addr;
  logic [6:0]             bit_cnt;
  logic [6:0]             data_bits;
  logic [SHIFT_WIDTH-1:0] data_shift;
  logic [SHIFT_WIDTH-1:0] next_data;
  logic [SHIFT_WIDTH-1:0] rx_word;
  logic [SHIFT_WIDTH-1:0] rd_word;
  logic [6:0]             rd_idx;
  logic                   last_bit;

  assign data_bits = {reg_bytes(addr), 3'b000};
  assign last_bit  = (bit_cnt == data_bits - 7'h01);

  // The bit order follows the live order setting for instruction and data
  always_comb
  begin
    next_instr = lsb_first_in ? {sdio_s, instr_shift[7:1]} : {instr_shift[6:0], sdio_s};
    next_data  = lsb_first_in ? {sdio_s, data_shift[SHIFT_WIDTH-1:1]}
                              : {data_shift[SHIFT_WIDTH-2:0], sdio_s};
    rx_word    = lsb_first_in ? (next_data >> (7'd64 - data_bits)) : next_data;
    rd_idx     = lsb_first_in ? bit_cnt : (data_bits - 7'h01 - bit_cnt);
  end

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      state       <= ST_INSTR;
      instr_shift <= 8'h00;
      addr        <= 5'h00;
      bit_cnt     <= 7'h00;
      data_shift  <= '0;
    end
    else if (ce_in)
    begin
      if (io_reset_s)
      begin
        // Abort without touching register contents
        state   <= ST_INSTR;
        bit_cnt <= 7'h00;
      end
      else if (sclk_rise)
      begin
        case (state)
          ST_INSTR:
          begin
            instr_shift <= next_instr;
            if (bit_cnt == INSTR_BITS - 7'h01)
            begin
              addr       <= next_instr[4:0];
              bit_cnt    <= 7'h00;
              data_shift <= '0;
              state      <= next_instr[INSTR_READ_BIT] ? ST_READ : ST_WRITE;
            end
            else
            begin
              bit_cnt <= bit_cnt + 7'h01;
            end
          end
          ST_WRITE, ST_READ:
          begin
            data_shift <= next_data;
            if (last_bit)
            begin
              bit_cnt <= 7'h00;
              state   <= ST_INSTR;
            end
            else
            begin
              bit_cnt <= bit_cnt + 7'h01;
            end
          end
          default:
          begin
            state   <= ST_INSTR;
            bit_cnt <= 7'h00;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Register commit after the final bit of a write
  logic commit;

  assign commit = sclk_rise && (state == ST_WRITE) && last_bit;

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      second_control_out       <= SECOND_CONTROL_RESET;
      rising_delta_tuning_out  <= DELTA_RESET;
      falling_delta_tuning_out <= DELTA_RESET;
      rising_ramp_rate_out     <= RAMP_RESET;
      falling_ramp_rate_out    <= RAMP_RESET;
      profile_zero_out         <= PROFILE_RESET;
      profile_one_out          <= PROFILE_RESET;
    end
    else if (ce_in && commit)
    begin
      // Open bits are held at zero so a stray host write cannot set them
      if (addr == ADDR_SECOND_CONTROL)
      begin
        second_control_out <= rx_word[39:0] & SECOND_CONTROL_MASK;
      end
      else if (addr == ADDR_RISING_DELTA)
      begin
        rising_delta_tuning_out <= rx_word[23:0];
      end
      else if (addr == ADDR_FALLING_DELTA)
      begin
        falling_delta_tuning_out <= rx_word[23:0];
      end
      else if (addr == ADDR_RISING_RAMP)
      begin
        rising_ramp_rate_out <= rx_word[15:0];
      end
      else if (addr == ADDR_FALLING_RAMP)
      begin
        falling_ramp_rate_out <= rx_word[15:0];
      end
      else if (addr == ADDR_PROFILE_ZERO)
      begin
        profile_zero_out <= {2'b00, rx_word[61:0]};
      end
      else if (addr == ADDR_PROFILE_ONE)
      begin
        profile_one_out <= {2'b00, rx_word[61:0]};
      end
    end
  end

  // ==========================================================================
  // Read path; unmapped addresses read as zero
  always_comb
  begin
    rd_word = '0;
    if (addr == ADDR_SECOND_CONTROL)
    begin
      rd_word[39:0] = second_control_out;
    end
    else if (addr == ADDR_RISING_DELTA)
    begin
      rd_word[23:0] = rising_delta_tuning_out;
    end
    else if (addr == ADDR_FALLING_DELTA)
    begin
      rd_word[23:0] = falling_delta_tuning_out;
    end
    else if (addr == ADDR_RISING_RAMP)
    begin
      rd_word[15:0] = rising_ramp_rate_out;
    end
    else if (addr == ADDR_FALLING_RAMP)
    begin
      rd_word[15:0] = falling_ramp_rate_out;
    end
    else if (addr == ADDR_PROFILE_ZERO)
    begin
      rd_word = profile_zero_out;
    end
    else if (addr == ADDR_PROFILE_ONE)
    begin
      rd_word = profile_one_out;
    end
  end

  // Data leaves on the falling serial clock edge
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      sdio_out    <= 1'b0;
      sdo_out     <= 1'b0;
      sdio_oe_out <= 1'b0;
      sdo_oe_out  <= 1'b0;
    end
    else if (ce_in)
    begin
      if (sclk_fall && state == ST_READ)
      begin
        sdio_out <= rd_word[rd_idx[5:0]];
        sdo_out  <= rd_word[rd_idx[5:0]];
      end
      // Both pins float while deselected or outside a read
      sdio_oe_out <= (state == ST_READ) && !cs_n_s && !io_reset_s && !sdio_input_only_in;
      sdo_oe_out  <= (state == ST_READ) && !cs_n_s && !io_reset_s && sdio_input_only_in;
    end
  end

endmodule

// ==== scb_pkg.sv ====
/*
  Shared constants and types of the synthesizer configuration register bank:
  serial addresses, register lengths, reset values, field layouts and states.
  Assumes the importing modules run on one clock and share this package.
*/
// How it works
// - The second control register holds divider M in bits 11:8 and divider N in bits 15:12.
// - The low byte of the second control register resets to 0x07 with charge pump scale in 2:0.
// - A 24-bit rising delta tuning word at address 0x02 resets to zero.
// - A 24-bit falling delta tuning word at address 0x03 resets to zero.
// - Rising and falling 16-bit ramp rate registers sit at 0x04 and 0x05 and reset to zero.
// - Profile zero at 0x06 is 64 bits with a 14-bit phase offset ending at bit 61.
// - Profile zero holds a 48-bit tuning word in its low six bytes, top byte at 47:40.
// - Profile one at 0x07 has the same layout as profile zero.
// - Every byte of both profiles resets to 0x00.
// - The low five bits of the instruction byte select the register to access.
package scb_pkg;

  // ==========================================================================
  // Serial addresses
  localparam logic [4:0] ADDR_FIRST_CONTROL  = 5'h00;
  localparam logic [4:0] ADDR_SECOND_CONTROL = 5'h01;
  localparam logic [4:0] ADDR_RISING_DELTA   = 5'h02;
  localparam logic [4:0] ADDR_FALLING_DELTA  = 5'h03;
  localparam logic [4:0] ADDR_RISING_RAMP    = 5'h04;
  localparam logic [4:0] ADDR_FALLING_RAMP   = 5'h05;
  localparam logic [4:0] ADDR_PROFILE_ZERO   = 5'h06;
  localparam logic [4:0] ADDR_PROFILE_ONE    = 5'h07;
  localparam logic [4:0] ADDR_PROFILE_LAST   = 5'h0d;

  // ==========================================================================
  // Transfer lengths in bytes and instruction layout
  localparam logic [3:0] LEN_FIRST_CONTROL  = 4'h4;
  localparam logic [3:0] LEN_SECOND_CONTROL = 4'h5;
  localparam logic [3:0] LEN_DELTA          = 4'h3;
  localparam logic [3:0] LEN_RAMP           = 4'h2;
  localparam logic [3:0] LEN_PROFILE        = 4'h8;
  localparam logic [3:0] LEN_UNMAPPED       = 4'h1;
  localparam logic [6:0] INSTR_BITS         = 7'h08;
  localparam int         INSTR_READ_BIT     = 7;
  localparam int         SHIFT_WIDTH        = 64;

  // ==========================================================================
  // Reset values and writable masks
  localparam logic [39:0] SECOND_CONTROL_RESET = 40'h00_0078_0007;
  localparam logic [39:0] SECOND_CONTROL_MASK  = 40'h83_ffff_ff3f;
  localparam logic [23:0] DELTA_RESET          = 24'h00_0000;
  localparam logic [15:0] RAMP_RESET           = 16'h0000;
  localparam logic [63:0] PROFILE_RESET        = 64'h0000_0000_0000_0000;

  // ==========================================================================
  // Field layouts
  typedef struct packed {
    logic [15:0] upper_control;
    logic        rf_div_power_down;
    logic [1:0]  rf_div_ratio;
    logic        clk_drv_power_down;
    logic [1:0]  clk_drv_select;
    logic        slew_rate_control;
    logic        rf_div_refclk_mux;
    logic [3:0]  divider_n;
    logic [3:0]  divider_m;
    logic [1:0]  open_low;
    logic        charge_pump_polarity;
    logic        charge_pump_full_pd;
    logic        charge_pump_quick_pd;
    logic [2:0]  charge_pump_scale;
  } scb_second_control_s;

  typedef struct packed {
    logic [1:0]  open_top;
    logic [13:0] phase_offset;
    logic [47:0] tuning_word;
  } scb_profile_s;

  typedef enum logic [1:0] {
    ST_INSTR = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ  = 2'b10
  } scb_state_e;

endpackage

// ==== scb_pin_sync.sv ====
/*
  Three-stage input synchroniser with agreement filter for one pin.
  Assumes the pin is asynchronous to clock_in.
*/
`timescale 1ns/100ps
module scb_pin_sync
  import scb_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b0
)
(
  input  wire logic clock_in,
  input  wire logic resetn_in,
  input  wire logic ce_in,
  input  wire logic pin_in,
  output logic      level_out
);

  logic stage1;
  logic stage2;
  logic stage3;

  // ==========================================================================
  // Stage chain; only stage two reads stage one
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      stage1    <= RESET_LEVEL;
      stage2    <= RESET_LEVEL;
      stage3    <= RESET_LEVEL;
      level_out <= RESET_LEVEL;
    end
    else if (ce_in)
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      // A change counts only once two later stages agree
      if (stage2 == stage3)
      begin
        level_out <= stage3;
      end
    end
  end

endmodule

// ==== scb_register_bank_monitor.sv ====
/*
  Port checker of the configuration register bank.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/100ps
module scb_register_bank_monitor
  import scb_pkg::*;
(
  input wire logic                clock_in,
  input wire logic                resetn_in,
  input wire logic                cs_n_in,
  input wire logic                sdio_input_only_in,
  input wire logic                sdio_oe_out,
  input wire logic                sdo_oe_out,
  input wire scb_second_control_s second_control_out,
  input wire logic [23:0]         rising_delta_tuning_out,
  input wire logic [15:0]         rising_ramp_rate_out,
  input wire scb_profile_s        profile_zero_out,
  input wire scb_profile_s        profile_one_out
);
  // ==========================================================================
  // Properties
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);

  property p_reset_vals;
    $rose(resetn_in) |-> second_control_out == SECOND_CONTROL_RESET
      && profile_zero_out == PROFILE_RESET && profile_one_out == PROFILE_RESET;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

  property p_ctl_open;
    (second_control_out & ~SECOND_CONTROL_MASK) == 40'h0;
  endproperty
  a_ctl_open: assert property (p_ctl_open) else $error("control open bit set");

  property p_prof_open;
    profile_zero_out.open_top == 2'h0 && profile_one_out.open_top == 2'h0;
  endproperty
  a_prof_open: assert property (p_prof_open) else $error("profile open bit set");

  // Six idle cycles cover the pin filter, so no commit may land while deselected
  property p_delta_hold;
    cs_n_in [*6] |-> $stable(rising_delta_tuning_out);
  endproperty
  a_delta_hold: assert property (p_delta_hold) else $error("delta moved idle");

  property p_ramp_hold;
    cs_n_in [*6] |-> $stable(rising_ramp_rate_out);
  endproperty
  a_ramp_hold: assert property (p_ramp_hold) else $error("ramp moved idle");

  property p_prof_hold;
    cs_n_in [*6] |-> $stable(profile_zero_out) && $stable(profile_one_out);
  endproperty
  a_prof_hold: assert property (p_prof_hold) else $error("profile moved idle");

  property p_pin_sdio;
    sdio_input_only_in |-> !sdio_oe_out;
  endproperty
  a_pin_sdio: assert property (p_pin_sdio) else $error("sdio driven");

  property p_pin_sdo;
    !sdio_input_only_in |-> !sdo_oe_out;
  endproperty
  a_pin_sdo: assert property (p_pin_sdo) else $error("sdo driven");

  property p_cs_idle;
    cs_n_in [*6] |-> !sdio_oe_out && !sdo_oe_out;
  endproperty
  a_cs_idle: assert property (p_cs_idle) else $error("driven while deselected");

  c_sdio_read: cover property ($rose(sdio_oe_out));
  c_sdo_read: cover property ($rose(sdo_oe_out));
  c_prof_write: cover property ($changed(profile_one_out));
endmodule

bind scb_register_bank scb_register_bank_monitor scb_register_bank_monitor_inst (
  .clock_in, .resetn_in, .cs_n_in, .sdio_input_only_in, .sdio_oe_out, .sdo_oe_out,
  .second_control_out, .rising_delta_tuning_out, .rising_ramp_rate_out,
  .profile_zero_out, .profile_one_out
);

// ==== scb_host_model.sv ====
/*
  Serial host model: instruction byte then whole data bytes, optional abort.
  Assumes the bench resolves the shared data line into data_in.
*/
`timescale 1ns/100ps
module scb_host_model (
  input  wire logic clock_in,
  input  wire logic lsb_first_in,
  input  wire logic data_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      sdio_out,
  output logic      io_reset_out
);
  // Eight clocks a half period leaves margin over the pin filter
  localparam int HALF = 8;

  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdio_out = 1'b0;
    io_reset_out = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  // ==========================================================================
  // One transfer; cut is the bit index that triggers an abort, -1 for none;
  // cut plus 100 instead pauses chip select before that bit
  task automatic xfer(input logic [7:0] ins, input int nb, input logic [63:0] wd,
                      input int cut, output logic [63:0] rd);
    int k;
    int total;
    total = 8 + nb * 8;
    rd = 64'h0;
    cs_n_out = 1'b0;
    for (k = 0; k < total; k++)
    begin
      if (k == cut)
      begin
        io_reset_out = 1'b1;
        step(HALF);
        io_reset_out = 1'b0;
        cs_n_out = 1'b1;
        step(HALF);
        return;
      end
      if (k + 100 == cut)
      begin
        cs_n_out = 1'b1;
        step(HALF);
        cs_n_out = 1'b0;
      end
      if (k < 8)
        sdio_out = lsb_first_in ? ins[k] : ins[7 - k];
      else if (!ins[7])
        sdio_out = lsb_first_in ? wd[k - 8] : wd[total - 1 - k];
      else
        sdio_out = ~sdio_out;
      step(HALF);
      if (k >= 8 && lsb_first_in)
        rd[k - 8] = data_in;
      else if (k >= 8)
        rd[total - 1 - k] = data_in;
      sclk_out = 1'b1;
      step(HALF);
      sclk_out = 1'b0;
    end
    step(HALF);
    cs_n_out = 1'b1;
    sdio_out = ~sdio_out;
    // Deselect stays visible before the next transfer may begin
    step(HALF);
  endtask
endmodule

// ==== tb_top.sv ====
/*
  Self-checking bench of the register bank through its serial port.
  Assumes the host model and the checker compiled before it.
*/
`timescale 1ns/100ps
module tb_top
  import scb_pkg::*;
;
  typedef struct {
    logic [7:0]  ins;
    int          nb;
    logic [63:0] wd;
    logic [63:0] ex;
  } scb_row_s;
  logic                clock_in = 1'b0;
  logic                resetn_in = 1'b0;
  logic                ce_in = 1'b1;
  logic                lsb_first_in = 1'b0;
  logic                sdio_input_only_in = 1'b0;
  logic                sclk_in;
  logic                cs_n_in;
  logic                host_sdio;
  logic                io_reset_in;
  logic                sdio_out;
  logic                sdio_oe_out;
  logic                sdo_out;
  logic                sdo_oe_out;
  scb_second_control_s second_control_out;
  logic [23:0]         rising_delta_tuning_out;
  logic [23:0]         falling_delta_tuning_out;
  logic [15:0]         rising_ramp_rate_out;
  logic [15:0]         falling_ramp_rate_out;
  scb_profile_s        profile_zero_out;
  scb_profile_s        profile_one_out;
  logic [63:0]         rd;
  int                  error_cnt = 0;
  int                  num_checks = 0;
  wire logic           sdio_in = sdio_oe_out ? sdio_out : host_sdio;
  wire logic           rd_line = sdio_input_only_in ? (sdo_oe_out ? sdo_out : host_sdio) : sdio_in;
  scb_row_s            rows [7] = '{
    '{8'h01, 5, 64'hff_ffff_a5ff, 64'h83_ffff_a53f},
    '{8'h02, 3, 64'h12_3456, 64'h12_3456},
    '{8'h03, 3, 64'hab_cdef, 64'hab_cdef},
    '{8'h04, 2, 64'hbeef, 64'hbeef},
    '{8'h05, 2, 64'h1234, 64'h1234},
    '{8'h06, 8, 64'hffff_0123_4567_89ab, 64'h3fff_0123_4567_89ab},
    '{8'h07, 8, 64'h1a5a_fedc_ba98_7654, 64'h1a5a_fedc_ba98_7654}
  };

  always #2.5 clock_in = ~clock_in;

  scb_register_bank scb_register_bank_inst (
    .clock_in, .resetn_in, .ce_in, .sclk_in, .cs_n_in, .sdio_in, .io_reset_in,
    .lsb_first_in, .sdio_input_only_in, .sdio_out, .sdio_oe_out, .sdo_out, .sdo_oe_out,
    .second_control_out, .rising_delta_tuning_out, .falling_delta_tuning_out,
    .rising_ramp_rate_out, .falling_ramp_rate_out, .profile_zero_out, .profile_one_out
  );

  scb_host_model scb_host_model_inst (
    .clock_in, .lsb_first_in, .data_in(rd_line), .sclk_out(sclk_in), .cs_n_out(cs_n_in),
    .sdio_out(host_sdio), .io_reset_out(io_reset_in)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [63:0] reg_of(input logic [4:0] a);
    case (a)
      5'h01: return {24'h0, second_control_out};
      5'h02: return {40'h0, rising_delta_tuning_out};
      5'h03: return {40'h0, falling_delta_tuning_out};
      5'h04: return {48'h0, rising_ramp_rate_out};
      5'h05: return {48'h0, falling_ramp_rate_out};
      5'h06: return profile_zero_out;
      default: return profile_one_out;
    endcase
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apply_reset;
    resetn_in = 1'b0;
    repeat (6) @(negedge clock_in);
    resetn_in = 1'b1;
    repeat (6) @(negedge clock_in);
    for (int a = 1; a < 8; a++)
      check(reg_of(5'(a)), (a == 1) ? {24'h0, SECOND_CONTROL_RESET} : 64'h0);
  endtask

  task automatic tally_and_finish;
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Sequence
  initial
  begin
    apply_reset();
    foreach (rows[i])
    begin
      scb_host_model_inst.xfer(rows[i].ins, rows[i].nb, rows[i].wd, -1, rd);
      check(reg_of(rows[i].ins[4:0]), rows[i].ex);
      scb_host_model_inst.xfer(rows[i].ins | 8'h80, rows[i].nb, 64'h0, -1, rd);
      check(rd, rows[i].ex);
    end
    check({56'h0, second_control_out.divider_n, second_control_out.divider_m}, 64'ha5);
    check({61'h0, second_control_out.charge_pump_scale}, 64'h7);
    scb_host_model_inst.xfer(8'h64, 2, 64'h0f0f, -1, rd);
    check(reg_of(5'h04), 64'h0f0f);
    // A write while the clock enable is low must leave no trace
    ce_in = 1'b0;
    scb_host_model_inst.xfer(8'h04, 2, 64'h5555, -1, rd);
    ce_in = 1'b1;
    check(reg_of(5'h04), 64'h0f0f);
    // Chip select pause mid-word suspends and then resumes the write
    scb_host_model_inst.xfer(8'h03, 3, 64'h77_6655, 112, rd);
    check(reg_of(5'h03), 64'h77_6655);
    lsb_first_in = 1'b1;
    scb_host_model_inst.xfer(8'h05, 2, 64'hc001, -1, rd);
    check(reg_of(5'h05), 64'hc001);
    scb_host_model_inst.xfer(8'h85, 2, 64'h0, -1, rd);
    check(rd, 64'hc001);
    lsb_first_in = 1'b0;
    // Abort mid-word must leave the old profile untouched
    scb_host_model_inst.xfer(8'h06, 8, 64'h0, 40, rd);
    check(reg_of(5'h06), 64'h3fff_0123_4567_89ab);
    // Profiles beyond the bank still frame eight data bytes
    scb_host_model_inst.xfer(8'h08, 8, 64'hff, -1, rd);
    scb_host_model_inst.xfer(8'h88, 8, 64'h0, -1, rd);
    check(rd, 64'h0);
    check(reg_of(5'h06), 64'h3fff_0123_4567_89ab);
    sdio_input_only_in = 1'b1;
    scb_host_model_inst.xfer(8'h82, 3, 64'h0, -1, rd);
    check(rd, 64'h12_3456);
    sdio_input_only_in = 1'b0;
    apply_reset();
    tally_and_finish();
  end

  initial
  begin
    repeat (60000) @(posedge clock_in);
    error_cnt++;
    tally_and_finish();
  end
endmodule
